// file: core/fts_pkg.sv
// constants, codes and register map shared by the frame trigger block
package fts_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_US = 1;
	localparam int CYC_PER_TICK = (CLK_HZ / 1_000_000) * TICK_US;
	localparam int DIVW = 6;
	localparam int EXPW = 23;
	// ---------------------------------------------------------------
	// register byte addresses and fields
	// ---------------------------------------------------------------
	localparam logic [7:0] ADR_TRIG = 8'h00;
	localparam logic [7:0] ADR_EXP = 8'h04;
	localparam logic [7:0] ADR_TIME = 8'h08;
	localparam logic [7:0] ADR_SOFT = 8'h0c;
	localparam logic [7:0] ADR_LINE = 8'h10;
	localparam logic [7:0] ADR_STAT = 8'h14;
	localparam int TRIG_MODE_BIT = 0;
	localparam int TRIG_SRC_LSB = 4;
	localparam int TRIG_ACT_LSB = 8;
	localparam int EXP_MODE_LSB = 0;
	localparam int AUTO_BIT = 4;
	localparam int OVL_BIT = 8;
	localparam int LINE_SRC_LSB = 0;
	localparam int TTL_INV_BIT = 4;
	localparam int GATE_INV_LSB = 8;
	localparam int USER_LSB = 16;
	// ---------------------------------------------------------------
	// reset values and limits
	// ---------------------------------------------------------------
	localparam logic RST_TRIG_MODE = 1'b0;
	localparam logic [3:0] RST_TRIG_SRC = 4'hd;
	localparam logic [1:0] RST_ACT = 2'h0;
	localparam logic [1:0] RST_EXP_MODE = 2'h1;
	localparam logic [EXPW-1:0] RST_EXP_TIME = 23'd18000;
	localparam logic [EXPW-1:0] EXP_MIN_US = 23'd15;
	localparam logic [EXPW-1:0] EXP_MAX_US = 23'd8000000;
	localparam logic [EXPW-1:0] AE_STEP_US = 23'd100;
	localparam logic [3:0] RST_LINE_SRC = 4'h0;
	// ---------------------------------------------------------------
	// selector codes
	// ---------------------------------------------------------------
	localparam int SRC_LOW = 0;
	localparam int SRC_HIGH = 1;
	localparam int SRC_SOFT = 2;
	localparam int SRC_TWAIT = 3;
	localparam int SRC_FACT = 4;
	localparam int SRC_EXPACT = 5;
	localparam int SRC_FVAL = 6;
	localparam int SRC_LVAL = 7;
	localparam int SRC_PG0 = 8;
	localparam int SRC_USER0 = 10;
	localparam int SRC_USER1 = 11;
	localparam int SRC_TTL = 12;
	localparam int SRC_CC1 = 13;
	localparam int SRC_GATE0 = 14;
	localparam int SRC_GATE1 = 15;
	localparam logic [15:0] TRIG_SRC_OK = 16'hfd07;
	localparam logic [15:0] LINE_SRC_OK = 16'hfdfb;
	localparam logic [1:0] ACT_RISE = 2'h0;
	localparam logic [1:0] ACT_FALL = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_LOW = 2'h3;
	localparam logic [1:0] EXP_OFF = 2'h0;
	localparam logic [1:0] EXP_TIMED = 2'h1;
	localparam logic [1:0] EXP_WIDTH = 2'h2;
	typedef enum logic [1:0] {ST_WAIT, ST_EXPOSE, ST_READOUT} fts_state_t;
endpackage

// file: core/fts_gate_if.sv
// carrier between the trigger core and its nand gate pair
`timescale 1ns/1ps
interface fts_gate_if;
	logic [1:0] in1;
	logic [1:0] in2;
	logic [1:0] inv1;
	logic [1:0] inv2;
	logic [1:0] out;
	modport core (output in1, output in2, output inv1, output inv2, input out);
	modport gate (input in1, input in2, input inv1, input inv2, output out);
endinterface

// file: core/fts_nand.sv
// two registered nand gates with an inverter on every input
`timescale 1ns/1ps
module fts_nand (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	fts_gate_if.gate g
);
	import fts_pkg::*;
	logic [1:0] out_ff;
	assign g.out = out_ff;
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : gen_gate
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					out_ff[i] <= 1'b1;
				end else if (ce) begin
					out_ff[i] <= ~((g.in1[i] ^ g.inv1[i]) & (g.in2[i] ^ g.inv2[i]));
				end
			end
			a_gate_nand_func: assert property (@(posedge clk) disable iff (!resetn)
				ce |=> out_ff[i] == ~(($past(g.in1[i]) ^ $past(g.inv1[i])) & ($past(g.in2[i]) ^ $past(g.inv2[i]))))
				else $error("nand gate output wrong");
		end
	endgenerate
endmodule // fts_nand

// file: core/fts_trig_top.sv
// frame start trigger, exposure sequencing and ttl line routing
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ps
module fts_trig_top (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CE,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic TTL_IN,
	input wire logic CC1_IN,
	input wire logic PULSE_GEN0_IN,
	input wire logic FRAME_ACTIVE_IN,
	input wire logic FVAL_IN,
	input wire logic LVAL_IN,
	input wire logic READOUT_DONE,
	input wire logic AE_BRIGHT,
	input wire logic AE_DARK,
	input wire logic [fts_pkg::EXPW-1:0] EXP_LIMIT_US,
	output logic TTL_OUT,
	output logic FRAME_START,
	output logic READOUT_START,
	output logic EXPOSING,
	output logic TRIGGER_WAIT
);
	import fts_pkg::*;

	// ---------------------------------------------------------------
	// settings
	// ---------------------------------------------------------------
	logic frame_trigger_mode_ff;
	logic [3:0] trigger_source_sel_ff;
	logic [1:0] trigger_activation_ff;
	logic [1:0] exposure_mode_sel_ff;
	logic auto_exposure_en_ff;
	logic overlap_mode_ff;
	logic [EXPW-1:0] exposure_time_us_ff;
	logic [3:0] line1_source_sel_ff;
	logic ttl_out_invert_ff;
	logic [3:0] gate_invert_ff;
	logic user_bit0_ff;
	logic user_bit1_ff;

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	logic ack_ff;
	logic [31:0] rd_data_ff;
	logic [31:0] rd_word;
	logic acc_w;
	logic [31:0] wmask;
	logic soft_pulse_ff;
	logic [31:0] trig_word;
	logic [31:0] exp_word;
	logic [31:0] line_word;
	logic [31:0] trig_new;
	logic [31:0] exp_new;
	logic [31:0] line_new;
	logic [31:0] time_new;

	assign WB_ACK_O = ack_ff;
	assign WB_DAT_O = rd_data_ff;
	// a write lands on the same edge at which the master sees ack
	assign acc_w = WB_CYC_I & WB_STB_I & WB_WE_I & ack_ff;
	assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

	always_comb begin
		trig_word = 32'h0;
		trig_word[TRIG_MODE_BIT] = frame_trigger_mode_ff;
		trig_word[TRIG_SRC_LSB +: 4] = trigger_source_sel_ff;
		trig_word[TRIG_ACT_LSB +: 2] = trigger_activation_ff;
		exp_word = 32'h0;
		exp_word[EXP_MODE_LSB +: 2] = exposure_mode_sel_ff;
		exp_word[AUTO_BIT] = auto_exposure_en_ff;
		exp_word[OVL_BIT] = overlap_mode_ff;
		line_word = 32'h0;
		line_word[LINE_SRC_LSB +: 4] = line1_source_sel_ff;
		line_word[TTL_INV_BIT] = ttl_out_invert_ff;
		line_word[GATE_INV_LSB +: 4] = gate_invert_ff;
		line_word[USER_LSB] = user_bit0_ff;
		line_word[USER_LSB + 1] = user_bit1_ff;
	end

	assign trig_new = (trig_word & ~wmask) | (WB_DAT_I & wmask);
	assign exp_new = (exp_word & ~wmask) | (WB_DAT_I & wmask);
	assign line_new = (line_word & ~wmask) | (WB_DAT_I & wmask);
	assign time_new = ({9'h0, exposure_time_us_ff} & ~wmask) | (WB_DAT_I & wmask);

	// ---------------------------------------------------------------
	// sequencer state (declared early, read by status)
	// ---------------------------------------------------------------
	fts_state_t state_ff;
	fts_state_t nxt_state;
	logic pend_ff;
	logic trig_q_ff;
	logic [EXPW-1:0] exp_cnt_ff;

	always_comb begin
		rd_word = 32'h0;
		unique case (WB_ADR_I)
			ADR_TRIG: rd_word = trig_word;
			ADR_EXP: rd_word = exp_word;
			ADR_TIME: rd_word = {9'h0, exposure_time_us_ff};
			ADR_LINE: rd_word = line_word;
			ADR_STAT: rd_word = {21'h0, trig_q_ff, pend_ff, state_ff == ST_READOUT,
				state_ff == ST_EXPOSE, state_ff == ST_WAIT, 6'h0};
			default: rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ack_ff <= 1'b0;
			rd_data_ff <= 32'h0;
		end else if (CE) begin
			ack_ff <= WB_CYC_I & WB_STB_I & ~ack_ff;
			rd_data_ff <= rd_word;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			soft_pulse_ff <= 1'b0;
		end else if (CE) begin
			soft_pulse_ff <= acc_w && WB_ADR_I == ADR_SOFT && WB_DAT_I == 32'h0;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			frame_trigger_mode_ff <= RST_TRIG_MODE;
			trigger_source_sel_ff <= RST_TRIG_SRC;
			trigger_activation_ff <= RST_ACT;
		end else if (CE && acc_w && WB_ADR_I == ADR_TRIG) begin
			frame_trigger_mode_ff <= trig_new[TRIG_MODE_BIT];
			if (TRIG_SRC_OK[trig_new[TRIG_SRC_LSB +: 4]]) begin
				trigger_source_sel_ff <= trig_new[TRIG_SRC_LSB +: 4];
			end
			trigger_activation_ff <= trig_new[TRIG_ACT_LSB +: 2];
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			exposure_mode_sel_ff <= RST_EXP_MODE;
			auto_exposure_en_ff <= 1'b0;
			overlap_mode_ff <= 1'b0;
		end else if (CE && acc_w && WB_ADR_I == ADR_EXP) begin
			if (exp_new[EXP_MODE_LSB +: 2] != 2'h3) begin
				exposure_mode_sel_ff <= exp_new[EXP_MODE_LSB +: 2];
			end
			auto_exposure_en_ff <= exp_new[AUTO_BIT];
			overlap_mode_ff <= exp_new[OVL_BIT];
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			line1_source_sel_ff <= RST_LINE_SRC;
			ttl_out_invert_ff <= 1'b0;
			gate_invert_ff <= 4'h0;
			user_bit0_ff <= 1'b0;
			user_bit1_ff <= 1'b0;
		end else if (CE && acc_w && WB_ADR_I == ADR_LINE) begin
			if (LINE_SRC_OK[line_new[LINE_SRC_LSB +: 4]]) begin
				line1_source_sel_ff <= line_new[LINE_SRC_LSB +: 4];
			end
			ttl_out_invert_ff <= line_new[TTL_INV_BIT];
			gate_invert_ff <= line_new[GATE_INV_LSB +: 4];
			user_bit0_ff <= line_new[USER_LSB];
			user_bit1_ff <= line_new[USER_LSB + 1];
		end
	end

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic ttl_m_ff;
	logic ttl_s_ff;
	logic cc1_m_ff;
	logic cc1_s_ff;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ttl_m_ff <= 1'b0;
			ttl_s_ff <= 1'b0;
			cc1_m_ff <= 1'b0;
			cc1_s_ff <= 1'b0;
		end else if (CE) begin
			ttl_m_ff <= TTL_IN;
			ttl_s_ff <= ttl_m_ff;
			cc1_m_ff <= CC1_IN;
			cc1_s_ff <= cc1_m_ff;
		end
	end

	// ---------------------------------------------------------------
	// nand gates: gate0 ttl/pulse gen, gate1 cc1/user bit 1
	// ---------------------------------------------------------------
	fts_gate_if gif ();
	assign gif.in1 = {cc1_s_ff, ttl_s_ff};
	assign gif.in2 = {user_bit1_ff, PULSE_GEN0_IN};
	assign gif.inv1 = {gate_invert_ff[2], gate_invert_ff[0]};
	assign gif.inv2 = {gate_invert_ff[3], gate_invert_ff[1]};

	fts_nand u_nand (
		.clk(CLK),
		.resetn(RESETN),
		.ce(CE),
		.g(gif.gate)
	);

	// ---------------------------------------------------------------
	// source multiplexers
	// ---------------------------------------------------------------
	logic [15:0] src_vec;
	logic trig_prev_ff;
	logic ttl_out_ff;
	logic rise;
	logic fall;
	logic qual_evt;
	logic trig_on;

	always_comb begin
		src_vec = 16'h0;
		src_vec[SRC_HIGH] = 1'b1;
		src_vec[SRC_SOFT] = soft_pulse_ff;
		src_vec[SRC_TWAIT] = state_ff == ST_WAIT;
		src_vec[SRC_FACT] = FRAME_ACTIVE_IN;
		src_vec[SRC_EXPACT] = state_ff == ST_EXPOSE;
		src_vec[SRC_FVAL] = FVAL_IN;
		src_vec[SRC_LVAL] = LVAL_IN;
		src_vec[SRC_PG0] = PULSE_GEN0_IN;
		src_vec[SRC_USER0] = user_bit0_ff;
		src_vec[SRC_USER1] = user_bit1_ff;
		src_vec[SRC_TTL] = ttl_s_ff;
		src_vec[SRC_CC1] = cc1_s_ff;
		src_vec[SRC_GATE0] = gif.out[0];
		src_vec[SRC_GATE1] = gif.out[1];
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			trig_q_ff <= 1'b0;
			trig_prev_ff <= 1'b0;
		end else if (CE) begin
			trig_q_ff <= src_vec[trigger_source_sel_ff];
			trig_prev_ff <= trig_q_ff;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ttl_out_ff <= 1'b0;
		end else if (CE) begin
			ttl_out_ff <= src_vec[line1_source_sel_ff] ^ ttl_out_invert_ff;
		end
	end
	assign TTL_OUT = ttl_out_ff;

	assign rise = trig_q_ff & ~trig_prev_ff;
	assign fall = ~trig_q_ff & trig_prev_ff;
	assign trig_on = (trigger_activation_ff == ACT_RISE || trigger_activation_ff == ACT_HIGH) ? trig_q_ff : ~trig_q_ff;
	always_comb begin
		unique case (trigger_activation_ff)
			ACT_RISE: qual_evt = rise;
			ACT_FALL: qual_evt = fall;
			ACT_HIGH: qual_evt = trig_q_ff;
			ACT_LOW: qual_evt = ~trig_q_ff;
		endcase
	end

	// ---------------------------------------------------------------
	// frame sequencer
	// ---------------------------------------------------------------
	logic [DIVW-1:0] div_ff;
	logic tick;
	logic [EXPW-1:0] eff_time;
	logic go;
	logic exp_end;
	logic fs_ff;
	logic rs_ff;

	assign tick = div_ff == DIVW'(CYC_PER_TICK - 1);
	assign eff_time = (exposure_time_us_ff > EXP_LIMIT_US) ? EXP_LIMIT_US : exposure_time_us_ff;
	assign go = ~frame_trigger_mode_ff | qual_evt | pend_ff;
	assign exp_end = (exposure_mode_sel_ff == EXP_WIDTH) ? ~trig_on :
		(tick && exp_cnt_ff + 23'd1 >= eff_time);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_WAIT: begin
				if (go) begin
					nxt_state = (exposure_mode_sel_ff == EXP_OFF) ? ST_READOUT : ST_EXPOSE;
				end
			end
			ST_EXPOSE: begin
				if (exp_end) begin
					nxt_state = ST_READOUT;
				end
			end
			ST_READOUT: begin
				if (READOUT_DONE) begin
					nxt_state = ST_WAIT;
				end
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_ff <= ST_WAIT;
		end else if (CE) begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			pend_ff <= 1'b0;
		end else if (CE) begin
			if (state_ff == ST_READOUT && overlap_mode_ff && frame_trigger_mode_ff && qual_evt) begin
				pend_ff <= 1'b1;
			end else if (state_ff == ST_WAIT) begin
				pend_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			div_ff <= '0;
			exp_cnt_ff <= '0;
		end else if (CE) begin
			if (state_ff != ST_EXPOSE) begin
				div_ff <= '0;
				exp_cnt_ff <= '0;
			end else if (tick) begin
				div_ff <= '0;
				exp_cnt_ff <= exp_cnt_ff + 23'd1;
			end else begin
				div_ff <= div_ff + DIVW'(1);
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			fs_ff <= 1'b0;
			rs_ff <= 1'b0;
		end else if (CE) begin
			fs_ff <= state_ff == ST_WAIT && go;
			rs_ff <= state_ff != ST_READOUT && nxt_state == ST_READOUT;
		end
	end
	assign FRAME_START = fs_ff;
	assign READOUT_START = rs_ff;
	assign EXPOSING = state_ff == ST_EXPOSE;
	assign TRIGGER_WAIT = state_ff == ST_WAIT;

	// auto exposure steps per frame; a bus write wins
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			exposure_time_us_ff <= RST_EXP_TIME;
		end else if (CE) begin
			if (acc_w && WB_ADR_I == ADR_TIME) begin
				if (time_new <= {9'h0, EXP_MAX_US} && time_new >= {9'h0, EXP_MIN_US}) begin
					exposure_time_us_ff <= time_new[EXPW-1:0];
				end
			end else if (auto_exposure_en_ff && rs_ff) begin
				if (AE_BRIGHT && exposure_time_us_ff >= EXP_MIN_US + AE_STEP_US) begin
					exposure_time_us_ff <= exposure_time_us_ff - AE_STEP_US;
				end else if (AE_DARK && exposure_time_us_ff + AE_STEP_US <= EXP_MAX_US) begin
					exposure_time_us_ff <= exposure_time_us_ff + AE_STEP_US;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_soft_write;
		CE && acc_w && WB_ADR_I == ADR_SOFT && WB_DAT_I == 32'h0;
	endsequence
	sequence s_expose_end;
		CE && state_ff == ST_EXPOSE && exp_end;
	endsequence

	a_soft_trig_pulse: assert property (@(posedge CLK) disable iff (!RESETN)
		s_soft_write |=> soft_pulse_ff)
		else $error("soft trigger pulse missing");
	a_free_run_start: assert property (@(posedge CLK) disable iff (!RESETN)
		(CE && state_ff == ST_WAIT && !frame_trigger_mode_ff) |=> fs_ff)
		else $error("free run frame not started");
	a_mode_on_waits: assert property (@(posedge CLK) disable iff (!RESETN)
		(CE && state_ff == ST_WAIT && frame_trigger_mode_ff && !qual_evt && !pend_ff) |=> state_ff == ST_WAIT)
		else $error("frame started without trigger");
	a_rise_qualify: assert property (@(posedge CLK) disable iff (!RESETN)
		(CE && state_ff == ST_WAIT && frame_trigger_mode_ff && trigger_activation_ff == ACT_RISE &&
		trig_q_ff && !trig_prev_ff) |=> fs_ff)
		else $error("rising edge qualifier wrong");
	a_expose_readout: assert property (@(posedge CLK) disable iff (!RESETN)
		s_expose_end |=> (state_ff == ST_READOUT && rs_ff))
		else $error("exposure end did not start read-out");
	a_time_range_kept: assert property (@(posedge CLK) disable iff (!RESETN)
		exposure_time_us_ff >= EXP_MIN_US && exposure_time_us_ff <= EXP_MAX_US)
		else $error("exposure time out of range");
	a_bad_src_kept: assert property (@(posedge CLK) disable iff (!RESETN)
		(CE && acc_w && WB_ADR_I == ADR_TRIG && !TRIG_SRC_OK[trig_new[TRIG_SRC_LSB +: 4]])
		|=> $stable(trigger_source_sel_ff))
		else $error("unsupported source code stored");
	a_ttl_out_map: assert property (@(posedge CLK) disable iff (!RESETN)
		CE |=> TTL_OUT == ($past(src_vec[line1_source_sel_ff]) ^ $past(ttl_out_invert_ff)))
		else $error("ttl output mapping wrong");
	a_overlap_off_drop: assert property (@(posedge CLK) disable iff (!RESETN)
		(CE && state_ff == ST_READOUT && !overlap_mode_ff && !pend_ff) |=> !pend_ff)
		else $error("trigger held without overlap");
	a_ack_one_cycle: assert property (@(posedge CLK) disable iff (!RESETN)
		(CE && ack_ff) |=> !ack_ff)
		else $error("ack held longer than one cycle");
endmodule // fts_trig_top

// file: verif/fts_grabber.sv
// far side model: control line and sensor read-out timing
`timescale 1ns/1ps
module fts_grabber (
	input wire logic clk,
	input wire logic resetn,
	input wire logic frame_start,
	input wire logic readout_start,
	input wire logic slow,
	input wire logic cc1_cmd,
	output logic cc1,
	output logic readout_done,
	output logic fval,
	output logic lval,
	output logic frame_active,
	output logic pulse_gen0
);
	logic [7:0] cnt_ff;
	logic busy_ff;
	logic act_ff;
	logic [3:0] pg_ff;
	// slow read-out keeps the core out of its wait state for a while
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy_ff <= 1'b0;
			cnt_ff <= 8'h00;
		end else if (readout_start) begin
			busy_ff <= 1'b1;
			cnt_ff <= slow ? 8'h40 : 8'h02;
		end else if (readout_done) begin
			busy_ff <= 1'b0;
		end else if (busy_ff) begin
			cnt_ff <= cnt_ff - 8'h01;
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			act_ff <= 1'b0;
			pg_ff <= 4'h0;
			cc1 <= 1'b0;
		end else begin
			act_ff <= frame_start | (act_ff & ~readout_done);
			pg_ff <= pg_ff + 4'h1;
			cc1 <= cc1_cmd;
		end
	end
	assign readout_done = busy_ff & (cnt_ff == 8'h00);
	assign fval = busy_ff;
	assign lval = busy_ff & cnt_ff[0];
	assign frame_active = act_ff;
	assign pulse_gen0 = pg_ff[3];
endmodule // fts_grabber

// file: verif/tb.sv
// self-checking bench for the frame trigger block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_count++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
	import fts_pkg::*;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic req = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat, rd;
	logic ack, ttl_out, fstart, rstart, expo, twait, cc1, rdone, fval, lval, fact, pg0;
	logic slow = 1'b0;
	logic cc1_cmd = 1'b0;
	logic ttl_pin = 1'b0;
	logic ae_dark = 1'b0;
	int err_count = 0;
	int compares = 0;
	int cyc_cnt = 0;
	int n;
	logic [31:0] lv [12] = '{32'h1, 32'h9, 32'h11, 32'h1000a, 32'hb, 32'h2000b, 32'hf, 32'hc0f, 32'h2040f,
		32'hc, 32'h1c, 32'h10e};
	logic lo [12] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
	fts_trig_top fts_trig_top_inst (.CLK(CLK), .RESETN(RESETN), .CE(1'b1), .WB_CYC_I(req), .WB_STB_I(req),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.TTL_IN(ttl_pin), .CC1_IN(cc1), .PULSE_GEN0_IN(pg0), .FRAME_ACTIVE_IN(fact), .FVAL_IN(fval),
		.LVAL_IN(lval), .READOUT_DONE(rdone), .AE_BRIGHT(1'b0), .AE_DARK(ae_dark), .EXP_LIMIT_US(23'd2),
		.TTL_OUT(ttl_out), .FRAME_START(fstart), .READOUT_START(rstart), .EXPOSING(expo), .TRIGGER_WAIT(twait));
	fts_grabber fts_grabber_inst (.clk(CLK), .resetn(RESETN), .frame_start(fstart), .readout_start(rstart),
		.slow(slow), .cc1_cmd(cc1_cmd), .cc1(cc1), .readout_done(rdone), .fval(fval), .lval(lval),
		.frame_active(fact), .pulse_gen0(pg0));
	always #10 CLK = ~CLK;
	// a hang anywhere ends up in the same closing report
	always @(posedge CLK) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	task give_verdict;
		$display("comparisons %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// -----------------------------------------------------------------
	// bus and observation tasks
	// -----------------------------------------------------------------
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		req <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge CLK); while (ack !== 1'b1);
		rd = rdat;
		req <= 1'b0;
		we <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		`CHK(nm, e, rd)
	endtask
	task starts(input int lim, output int c);
		c = 0;
		repeat (lim) begin
			@(posedge CLK);
			if (fstart === 1'b1) c++;
		end
	endtask
	task wait_idle;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (twait !== 1'b1 && n < 3000);
		`CHK("wait_idle", 1'b1, twait)
	endtask
	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge CLK);
		RESETN <= 1'b1;
		rdchk(ADR_TRIG, 32'h000000d0, "trig");
		rdchk(ADR_EXP, 32'h00000001, "exp");
		rdchk(ADR_TIME, 32'h00004650, "time");
		rdchk(ADR_LINE, 32'h0, "line");
		rdchk(8'h20, 32'h0, "unmapped");
		wb(1'b1, ADR_TRIG, 32'h30);
		rdchk(ADR_TRIG, 32'h000000d0, "trig");
		wb(1'b1, ADR_EXP, 32'h3);
		rdchk(ADR_EXP, 32'h00000001, "exp");
		wb(1'b1, ADR_TIME, 32'd14);
		wb(1'b1, ADR_TIME, 32'd8000001);
		rdchk(ADR_TIME, 32'h00004650, "time");
		wb(1'b1, ADR_TIME, 32'd8000000);
		rdchk(ADR_TIME, 32'h007a1200, "time");
		// exposure capped by the 2 us frame limit
		wait_idle();
		while (expo !== 1'b1 && n < 6000) begin
			@(posedge CLK);
			n++;
		end
		n = 0;
		while (expo === 1'b1 && n < 2000) begin
			@(posedge CLK);
			n++;
		end
		`CHK("expose_len", 2 * CYC_PER_TICK, n)
		`CHK("readout_start", 1'b1, rstart)
		// ttl pin high so its source and gate0 with in1 inverted are seen
		ttl_pin <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			wb(1'b1, ADR_LINE, lv[i]);
			repeat (4) @(posedge CLK);
			`CHK("ttl_out", lo[i], ttl_out)
		end
		slow <= 1'b1;
		wb(1'b1, ADR_TRIG, 32'h21);
		wait_idle();
		starts(60, n);
		`CHK("idle_starts", 1, n + 1)
		wb(1'b1, ADR_SOFT, 32'h0);
		starts(20, n);
		`CHK("soft_starts", 1, n)
		slow <= 1'b0;
		wb(1'b1, ADR_TRIG, 32'h1d1);
		wait_idle();
		cc1_cmd <= 1'b1;
		starts(30, n);
		`CHK("rise_starts", 0, n)
		cc1_cmd <= 1'b0;
		starts(30, n);
		`CHK("fall_starts", 1, n)
		wb(1'b1, ADR_EXP, 32'h2);
		wb(1'b1, ADR_TRIG, 32'h2d1);
		wait_idle();
		cc1_cmd <= 1'b1;
		repeat (150) @(posedge CLK);
		`CHK("width_expo", 1'b1, expo)
		cc1_cmd <= 1'b0;
		repeat (8) @(posedge CLK);
		`CHK("width_end", 1'b0, expo)
		wb(1'b1, ADR_TRIG, 32'h3d1);
		repeat (20) @(posedge CLK);
		`CHK("low_expo", 1'b1, expo)
		cc1_cmd <= 1'b1;
		repeat (8) @(posedge CLK);
		`CHK("low_end", 1'b0, expo)
		// timed, auto exposure and overlap on; second trigger lands in a slow read-out
		wb(1'b1, ADR_TIME, 32'd1000);
		wb(1'b1, ADR_EXP, 32'h111);
		wb(1'b1, ADR_TRIG, 32'h21);
		slow <= 1'b1;
		ae_dark <= 1'b1;
		wait_idle();
		wb(1'b1, ADR_SOFT, 32'h0);
		starts(110, n);
		`CHK("soft_again", 1, n)
		wb(1'b1, ADR_SOFT, 32'h0);
		starts(200, n);
		`CHK("overlap_starts", 1, n)
		rdchk(ADR_TIME, 32'd1000 + 2 * AE_STEP_US, "ae_time");
		give_verdict();
	end
endmodule // tb
